/* verilog/opmode_pkg.sv */
// constants shared by the operating mode and clock select block
// assumes a 20 MHz system clock and an AHB-Lite register bus
package opmode_pkg;
  // register indices: each register is one aligned word at four times its index
  localparam logic [15:0] IDX_SYSTEM_CONTROL_TWO = 16'hFFF1;
  localparam logic [15:0] IDX_MODE_CONTROL       = 16'hFFF4;
  localparam logic [15:0] IDX_MODE_STATUS        = 16'hFFF8;
  localparam logic [15:0] IDX_MEDIUM_DIVIDER     = 16'hFFFC;
  // register byte addresses on the bus
  localparam logic [17:0] ADDR_SYSTEM_CONTROL_TWO = {IDX_SYSTEM_CONTROL_TWO, 2'b00};
  localparam logic [17:0] ADDR_MODE_CONTROL       = {IDX_MODE_CONTROL, 2'b00};
  localparam logic [17:0] ADDR_MODE_STATUS        = {IDX_MODE_STATUS, 2'b00};
  localparam logic [17:0] ADDR_MEDIUM_DIVIDER     = {IDX_MEDIUM_DIVIDER, 2'b00};
  // system_control_two field positions
  localparam int BIT_NOISE_SEL = 4;
  localparam int BIT_DIRECT    = 3;
  localparam int BIT_LOW_SPEED = 2;
  localparam int BIT_MID_SPEED = 1;
  // mode_control field positions
  localparam int BIT_STANDBY   = 0;
  localparam int BIT_TIMER     = 1;
  // reset values
  localparam logic [1:0] RST_MEDIUM_DIVIDER = 2'h3;
  localparam logic       RST_NOISE_SEL      = 1'b1;
  localparam logic       RST_DIRECT         = 1'b0;
  localparam logic       RST_LOW_SPEED      = 1'b0;
  localparam logic       RST_MID_SPEED      = 1'b0;
  localparam logic       RST_STANDBY        = 1'b0;
  localparam logic       RST_TIMER          = 1'b0;
  // divider widths: osc/128 needs 7 bits of prescaler
  localparam int PRESCALE_W = 7;
  localparam logic [6:0] NOISE_DIV16_MASK = 7'h0F;
  localparam logic [6:0] NOISE_DIV4_MASK  = 7'h03;

  typedef enum logic [2:0] {
    MODE_HIGH, MODE_MEDIUM, MODE_SUB, MODE_SLEEP, MODE_STANDBY, MODE_WATCH
  } op_mode_e;
endpackage

/* verilog/clock_tick_gen.sv */
// prescaler producing one-cycle tick enables from the oscillator clock
// assumes clk_sys is the oscillator clock
`timescale 1ns/10ps
`default_nettype none
module clock_tick_gen
  import opmode_pkg::*;
#(
  parameter int W = PRESCALE_W
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // divider selection
  input  wire logic [1:0]   medium_code,
  input  wire logic         noise_sample_select,
  // ticks
  output logic              medium_tick,
  output logic              noise_tick
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [W-1:0] medium_mask;
  logic         next_medium_tick;
  logic         next_noise_tick;

  always_comb begin
    next_count = count + {{(W-1){1'b0}}, 1'b1};
    // osc/16 << code: 16, 32, 64, 128
    medium_mask = W'((16 << medium_code) - 1); // RQ1
    next_medium_tick = ((count & medium_mask) == medium_mask);
    next_noise_tick  = noise_sample_select ?
                       ((count & NOISE_DIV4_MASK) == NOISE_DIV4_MASK) :
                       ((count & NOISE_DIV16_MASK) == NOISE_DIV16_MASK); // RQ3
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count       <= '0;
      medium_tick <= 1'b0;
      noise_tick  <= 1'b0;
    end else begin
      count       <= next_count;
      medium_tick <= next_medium_tick;
      noise_tick  <= next_noise_tick;
    end
  end
endmodule // clock_tick_gen
`default_nettype wire

/* verilog/operating_mode_clock_select.sv */
// operating mode controller with medium-speed divider and noise sampler clock select
// assumes an AHB-Lite master, single word transfers, clk_sys as oscillator clock
//
// What this block does
// (RQ1) medium-speed clock is osc divided by 16, 32, 64 or 128 per code
// (RQ2) divider field writes take effect only in high-speed or sub-active mode
// (RQ3) noise sampler uses osc/16 when select is 0, osc/4 when 1
// (RQ4) software clears noise select when the oscillator is 2 to 20 MHz
// (RQ5) direct-transition flag allows sleep to jump between active and sub-active modes
// (RQ6) flag clear: sleep enters standby, watch or sleep mode
// (RQ7) flag set, high-speed, standby 0, middle 1, low 0: go medium-speed
// (RQ8) flag set, either active, standby, timer, low all 1: go sub-active
// (RQ9) flag set, medium-speed, middle and low both 0: go high-speed
// (RQ10) flag set, sub-active, standby 1, timer 1, low 0: high or medium by middle
// (RQ11) low-speed flag picks system clock or sub-clock when leaving watch
// (RQ12) middle-speed flag picks high or medium speed after a cancelled low-power mode
// (RQ13) refused divider writes leave stored value and division untouched
`timescale 1ns/10ps
`default_nettype none
module operating_mode_clock_select
  import opmode_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [17:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // cpu events
  input  wire logic         sleep_exec,
  input  wire logic         wake_event,
  // operating mode and clock ticks
  output logic [2:0]        op_mode,
  output logic              cpu_on_sub_clock,
  output logic              medium_tick,
  output logic              noise_tick
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [1:0] medium_divider;
  logic       noise_sample_select;
  logic       direct_transition_flag;
  logic       low_speed_flag;
  logic       middle_speed_flag;
  logic       standby_select;
  logic       timer_mode_bit;
  logic [1:0] next_medium_divider;
  logic       next_noise_sample_select;
  logic       next_direct_transition_flag;
  logic       next_low_speed_flag;
  logic       next_middle_speed_flag;
  logic       next_standby_select;
  logic       next_timer_mode_bit;

  // bus data-phase capture
  logic        wr_pending;
  logic        next_wr_pending;
  logic [17:0] wr_addr;
  logic [17:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic        addr_phase;

  op_mode_e mode;
  op_mode_e next_mode;
  logic     next_cpu_on_sub_clock;

  assign addr_phase = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // bus slave and register writes
  // ----------------------------------------------------------------
  always_comb begin
    next_medium_divider         = medium_divider;
    next_noise_sample_select    = noise_sample_select;
    next_direct_transition_flag = direct_transition_flag;
    next_low_speed_flag         = low_speed_flag;
    next_middle_speed_flag      = middle_speed_flag;
    next_standby_select         = standby_select;
    next_timer_mode_bit         = timer_mode_bit;
    next_wr_pending             = addr_phase && hwrite;
    next_wr_addr                = addr_phase ? haddr : wr_addr;
    next_hrdata                 = hrdata;
    if (wr_pending) begin
      case (wr_addr)
        ADDR_SYSTEM_CONTROL_TWO: begin
          next_noise_sample_select    = hwdata[BIT_NOISE_SEL]; // RQ3
          next_direct_transition_flag = hwdata[BIT_DIRECT];
          next_low_speed_flag         = hwdata[BIT_LOW_SPEED];
          next_middle_speed_flag      = hwdata[BIT_MID_SPEED];
        end
        ADDR_MODE_CONTROL: begin
          next_standby_select = hwdata[BIT_STANDBY];
          next_timer_mode_bit = hwdata[BIT_TIMER];
        end
        ADDR_MEDIUM_DIVIDER: begin
          // refused outside high-speed and sub-active; no error is signalled
          if (mode == MODE_HIGH || mode == MODE_SUB) begin // RQ2
            next_medium_divider = hwdata[1:0];
          end // RQ13
        end
        default: begin
        end
      endcase
    end
    if (addr_phase && !hwrite) begin
      case (haddr)
        ADDR_SYSTEM_CONTROL_TWO: next_hrdata = {27'h0, noise_sample_select,
                                   direct_transition_flag, low_speed_flag,
                                   middle_speed_flag, 1'b0};
        ADDR_MODE_CONTROL:   next_hrdata = {30'h0, timer_mode_bit, standby_select};
        ADDR_MODE_STATUS:    next_hrdata = {28'h0, cpu_on_sub_clock, mode};
        ADDR_MEDIUM_DIVIDER: next_hrdata = {30'h0, medium_divider};
        default:             next_hrdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_mode             = mode;
    next_cpu_on_sub_clock = cpu_on_sub_clock;
    case (mode)
      MODE_HIGH, MODE_MEDIUM: begin
        if (sleep_exec) begin
          if (direct_transition_flag && standby_select && timer_mode_bit &&
              low_speed_flag) begin
            next_mode = MODE_SUB; // RQ8
          end else if (direct_transition_flag && mode == MODE_HIGH &&
                       !standby_select && middle_speed_flag && !low_speed_flag) begin
            next_mode = MODE_MEDIUM; // RQ7
          end else if (direct_transition_flag && mode == MODE_MEDIUM &&
                       !middle_speed_flag && !low_speed_flag) begin
            next_mode = MODE_HIGH; // RQ9
          end else if (standby_select && timer_mode_bit) begin
            next_mode = MODE_WATCH; // RQ6
          end else if (standby_select) begin
            next_mode = MODE_STANDBY; // RQ6
          end else begin
            next_mode = MODE_SLEEP; // RQ6
          end // RQ5
        end
      end
      MODE_SUB: begin
        if (sleep_exec) begin
          if (direct_transition_flag && standby_select && timer_mode_bit &&
              !low_speed_flag) begin
            next_mode = middle_speed_flag ? MODE_MEDIUM : MODE_HIGH; // RQ10
          end else if (standby_select && timer_mode_bit) begin
            next_mode = MODE_WATCH;
          end else begin
            next_mode = MODE_SLEEP;
          end
        end
      end
      MODE_WATCH: begin
        if (wake_event) begin
          if (low_speed_flag) begin
            next_mode = MODE_SUB; // RQ11
          end else begin
            next_mode = middle_speed_flag ? MODE_MEDIUM : MODE_HIGH; // RQ12
          end
        end
      end
      MODE_SLEEP, MODE_STANDBY: begin
        // sleep entered from sub-active returns there
        if (wake_event) begin
          if (cpu_on_sub_clock) begin
            next_mode = MODE_SUB;
          end else begin
            next_mode = middle_speed_flag ? MODE_MEDIUM : MODE_HIGH; // RQ12
          end
        end
      end
      default: next_mode = MODE_HIGH;
    endcase
    if (next_mode != mode && next_mode != MODE_SLEEP && next_mode != MODE_STANDBY) begin
      next_cpu_on_sub_clock = (next_mode == MODE_SUB) || (next_mode == MODE_WATCH &&
                              cpu_on_sub_clock);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      medium_divider         <= RST_MEDIUM_DIVIDER;
      noise_sample_select    <= RST_NOISE_SEL;
      direct_transition_flag <= RST_DIRECT;
      low_speed_flag         <= RST_LOW_SPEED;
      middle_speed_flag      <= RST_MID_SPEED;
      standby_select         <= RST_STANDBY;
      timer_mode_bit         <= RST_TIMER;
      wr_pending             <= 1'b0;
      wr_addr                <= 18'h0;
      hrdata                 <= 32'h0;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
      mode                   <= MODE_HIGH;
      op_mode                <= 3'h0;
      cpu_on_sub_clock       <= 1'b0;
    end else begin
      medium_divider         <= next_medium_divider;
      noise_sample_select    <= next_noise_sample_select;
      direct_transition_flag <= next_direct_transition_flag;
      low_speed_flag         <= next_low_speed_flag;
      middle_speed_flag      <= next_middle_speed_flag;
      standby_select         <= next_standby_select;
      timer_mode_bit         <= next_timer_mode_bit;
      wr_pending             <= next_wr_pending;
      wr_addr                <= next_wr_addr;
      hrdata                 <= next_hrdata;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
      mode                   <= next_mode;
      op_mode                <= next_mode;
      cpu_on_sub_clock       <= next_cpu_on_sub_clock;
    end
  end

  // ----------------------------------------------------------------
  // clock tick generation
  // ----------------------------------------------------------------
  clock_tick_gen #(
    .W(PRESCALE_W)
  ) u_ticks (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .medium_code         (medium_divider),
    .noise_sample_select (noise_sample_select),
    .medium_tick         (medium_tick),
    .noise_tick          (noise_tick)
  );
endmodule // operating_mode_clock_select
`default_nettype wire

/* verification/opmode_sva.sv */
// port checker for the operating mode and clock select block
// assumes it is bound into operating_mode_clock_select
`timescale 1ns/10ps
`default_nettype none
module opmode_sva
  import opmode_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // observed outputs and events
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       sleep_exec,
  input wire logic       wake_event,
  input wire logic [2:0] op_mode,
  input wire logic       cpu_on_sub_clock,
  input wire logic       medium_tick,
  input wire logic       noise_tick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_BUS_OK:
    assert property (hreadyout && !hresp) else $error("bus stalled or errored");
  AST_MED_MIN:
    assert property (medium_tick |=> !medium_tick [*8] ##1 !medium_tick [*7])
    else $error("medium tick too soon");
  AST_MED_MAX:
    assert property (medium_tick |-> ##[16:128] medium_tick) else $error("medium tick late");
  AST_NOISE_MIN:
    assert property (noise_tick |=> !noise_tick [*3]) else $error("noise tick too soon");
  AST_NOISE_MAX:
    assert property (noise_tick |-> ##[4:16] noise_tick) else $error("noise tick late");
  AST_QUIET:
    assert property (!sleep_exec && !wake_event |=> $stable(op_mode))
    else $error("mode moved without event");
  AST_SLEEP_MOVES:
    assert property (sleep_exec && op_mode == MODE_HIGH |=> op_mode != MODE_HIGH)
    else $error("sleep ignored in high speed");
  AST_WAKE_ACTIVE:
    assert property (wake_event && op_mode inside {MODE_SLEEP, MODE_STANDBY, MODE_WATCH}
      |=> op_mode inside {MODE_HIGH, MODE_MEDIUM, MODE_SUB}) else $error("wake not active");
  AST_SUB_CLK:
    assert property (op_mode inside {MODE_HIGH, MODE_MEDIUM, MODE_SUB}
      |-> cpu_on_sub_clock == (op_mode == MODE_SUB)) else $error("cpu clock source wrong");
endmodule // opmode_sva

bind operating_mode_clock_select opmode_sva chk_u (
  .clk_sys(clk_sys), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_exec(sleep_exec), .wake_event(wake_event), .op_mode(op_mode),
  .cpu_on_sub_clock(cpu_on_sub_clock), .medium_tick(medium_tick), .noise_tick(noise_tick));
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the operating mode and clock select block
// assumes a single-slave AHB-Lite bus and a 20 MHz clock
`timescale 1ns/10ps
`default_nettype none
module testbench
  import opmode_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [17:0] haddr = 18'h00000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        sleep_exec = 1'b0;
  logic        wake_event = 1'b0;
  logic [31:0] hrdata, q, n;
  logic        hreadyout, hresp, cpu_on_sub_clock, medium_tick, noise_tick;
  logic [2:0]  op_mode;
  int          err_count = 0;
  int          samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  // hsize is tied: only whole words are moved
  operating_mode_clock_select dut_u (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec),
    .wake_event(wake_event), .op_mode(op_mode), .cpu_on_sub_clock(cpu_on_sub_clock),
    .medium_tick(medium_tick), .noise_tick(noise_tick));

  // ----
  // tasks
  // ----
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a stuck ready ends the run rather than hanging it
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      give_verdict;
    end
  endtask

  task automatic bus(input logic [17:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask

  task automatic ev(input logic w, input logic [2:0] e);
    if (w) wake_event <= 1'b1;
    else sleep_exec <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
    @(posedge clk_sys);
    chk({29'h0, op_mode}, {29'h0, e});
  endtask

  // first pass only lines up with a tick, second measures the period
  task automatic per(input logic nz, input logic [31:0] e);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while ((nz ? noise_tick : medium_tick) !== 1'b1 && n < 300);
    end
    chk(n, e);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(ADDR_SYSTEM_CONTROL_TWO, 32'h10);
    rd(ADDR_MEDIUM_DIVIDER, 32'h3);
    bus(18'h3FFC0, 1'b1, 32'hFF);
    rd(18'h3FFC0, 32'h0);
    for (int c = 0; c < 4; c++) begin
      bus(ADDR_MEDIUM_DIVIDER, 1'b1, 32'(c));
      per(1'b0, 32'h10 << c);
    end
    per(1'b1, 32'h4);
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'h0);
    per(1'b1, 32'h10);
    for (int k = 0; k < 3; k++) begin
      bus(ADDR_MODE_CONTROL, 1'b1, (k == 2) ? 32'h3 : 32'(k));
      ev(1'b0, 3'(MODE_SLEEP + k));
      ev(1'b1, MODE_HIGH);
    end
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'h2);
    bus(ADDR_MODE_CONTROL, 1'b1, 32'h0);
    ev(1'b0, MODE_SLEEP);
    ev(1'b1, MODE_MEDIUM);
    bus(ADDR_MEDIUM_DIVIDER, 1'b1, 32'h0);
    rd(ADDR_MEDIUM_DIVIDER, 32'h3);
    per(1'b0, 32'h80);
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'hC);
    bus(ADDR_MODE_CONTROL, 1'b1, 32'h3);
    ev(1'b0, MODE_SUB);
    bus(ADDR_MEDIUM_DIVIDER, 1'b1, 32'h1);
    rd(ADDR_MEDIUM_DIVIDER, 32'h1);
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'hA);
    ev(1'b0, MODE_MEDIUM);
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'h8);
    ev(1'b0, MODE_HIGH);
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'hA);
    bus(ADDR_MODE_CONTROL, 1'b1, 32'h0);
    ev(1'b0, MODE_MEDIUM);
    bus(ADDR_SYSTEM_CONTROL_TWO, 1'b1, 32'h4);
    bus(ADDR_MODE_CONTROL, 1'b1, 32'h3);
    ev(1'b0, MODE_WATCH);
    ev(1'b1, MODE_SUB);
    rd(ADDR_MODE_STATUS, 32'hA);
    chk({31'h0, cpu_on_sub_clock}, 32'h1);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
